// >>> hdl/timer_counter_pkg.sv
// Purpose: Shared constants for the 8-bit timer/counter with PWM.
// Assumes: Register word index times four gives the APB byte address.
// Notes: Field positions are bit numbers inside an 8-bit register.
package timer_counter_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PRESC_W = 7;
  // Register word indices; byte address is four times the index.
  localparam logic [9:0] IDX_MODE_CONTROL = 10'h0B4;
  localparam logic [9:0] IDX_COUNTER_VALUE = 10'h0B5;
  localparam logic [9:0] IDX_RELOAD_BUFFER = 10'h0B6;
  localparam logic [9:0] IDX_DUTY_COMPARE = 10'h0B7;
  localparam logic [9:0] IDX_STATUS_CONTROL = 10'h0B8;
  // Mode control fields.
  localparam int BIT_COUNT_ENABLE = 7;
  localparam int BIT_RATE_HI = 6;
  localparam int BIT_RATE_LO = 4;
  localparam int BIT_EXTERNAL_CLOCK = 3;
  localparam int BIT_HIGH_SPEED = 2;
  localparam int BIT_SINGLE_PULSE = 1;
  localparam int BIT_PULSE_OUTPUT = 0;
  // Status control fields.
  localparam int BIT_OVERFLOW_FLAG = 0;
  localparam int BIT_OVERFLOW_IEN = 1;
  // Values after reset, then fixed counter, prescaler and vector constants.
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNTER_VALUE = 8'h00;
  localparam logic [7:0] RST_RELOAD_BUFFER = 8'h00;
  localparam logic [7:0] RST_DUTY_COMPARE = 8'h00;
  localparam logic [7:0] COUNT_FULL_SCALE = 8'hFF;
  localparam logic [PRESC_W-1:0] PRESC_ALL_ONES = 7'h7F;
  localparam logic [15:0] OVERFLOW_VECTOR = 16'h000C;
  typedef enum logic [0:0] {APB_IDLE, APB_ACCESS} apb_phase_t;
endpackage

// >>> hdl/tick_if.sv
// Purpose: Carries a one-cycle count pulse between timer modules.
// Assumes: Single clock domain.
// Notes: The source drives the pulse; the destination only reads it.
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
  logic tick;
  modport src(output tick);
  modport dst(input tick);
endinterface
`default_nettype wire

// >>> hdl/rate_prescaler.sv
// Purpose: Divides an internal clock enable by 128 down to 1.
// Assumes: tick_in is a one-cycle enable pulse.
// Notes: The divider state is frozen while hold_in is high.
`timescale 1ns/1ns
`default_nettype none
module rate_prescaler
  import timer_counter_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic hold_in,
  input wire logic [2:0] rate_in,
  tick_if.src div_out
);
  logic [PRESC_W-1:0] div_q;
  logic pulse_q;
  logic [PRESC_W-1:0] ignore_mask;

  // Code 7 ignores every bit, code 0 needs all seven bits set.
  assign ignore_mask = PRESC_ALL_ONES << (3'h7 - rate_in);
  assign div_out.tick = pulse_q;

  // Free-running divide chain; holding keeps software's setup intact.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= '0;
      pulse_q <= 1'b0;
    end else if (hold_in) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= tick_in && ((div_q | ignore_mask) == PRESC_ALL_ONES);
      if (tick_in) begin
        div_q <= div_q + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/event_edge_detect.sv
// Purpose: Turns falling edges of the event pin into count pulses.
// Assumes: The pin is asynchronous to the core clock.
// Notes: Pulses narrower than one clock period may be missed.
`timescale 1ns/1ns
`default_nettype none
module event_edge_detect (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  tick_if.src edge_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic fall_q;

  assign edge_out.tick = fall_q;

  // Two-stage synchroniser, then an edge stage that reads only sync_q.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      fall_q <= prev_q && !sync_q;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/timer_counter_pwm_8bit.sv
// Purpose: 8-bit up timer/event counter with auto-reload and PWM.
// Assumes: fcpu_tick_in and hosc_tick_in are one-cycle enable pulses.
// Notes: APB slave, no wait states; the pin is shared with GPIO.
// How it works
// - Counter runs only while the count enable bit is set.
// - Each selected clock tick adds one; a tick at FF is an overflow.
// - Overflow sets a sticky flag that only software clears.
// - Overflow reloads the counter from the reload buffer, unless a counter write lands in the same cycle.
// - Reload buffer writes matter only from the next overflow onward.
// - Flag with interrupt enable requests the vector at 000C.
// - Green mode changes nothing here and never wakes the system.
// - External select counts pin events; else internal source used.
// - High-speed select picks oscillator clock, else instruction clock.
// - Prescale code 000 divides by 128, halving to 111 for 1.
// - External events bypass the prescaler completely.
// - Pulse output enable routes PWM to the pin, else GPIO.
// - Single-pulse off gives plain timer or continuous PWM.
// - Single pulse: overflow sets flag and clears pulse output.
// - Event mode counts falling edges of the event pin.
// - PWM low at duty match; at overflow high again only if duty exceeds reload.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module timer_counter_pwm_8bit
  import timer_counter_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fcpu_tick_in,
  input wire logic hosc_tick_in,
  input wire logic event_pin_in,
  input wire logic green_mode_in,
  input wire logic gpio_level_in,
  input wire logic gpio_oe_n_in,
  output logic pin_level_out,
  output logic pin_oe_n_out,
  output logic irq_request_out,
  output logic [15:0] irq_vector_out,
  output logic wake_request_out
);
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;
  logic [7:0] mode_q;
  logic [7:0] count_q;
  logic [7:0] reload_q;
  logic [7:0] duty_q;
  logic [7:0] duty_live_q;
  logic flag_q;
  logic ien_q;
  logic pwm_q;
  logic pready_q;
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;
  apb_phase_t phase_q;
  logic [9:0] word_idx;
  logic mapped;
  logic wr_stb;
  logic wr_mode;
  logic wr_count;
  logic wr_reload;
  logic wr_duty;
  logic wr_status;
  logic count_en;
  logic ext_sel;
  logic pulse_en;
  logic count_tick;
  logic overflow;
  logic [7:0] count_next;
  logic [7:0] rd_mux;
  tick_if presc_tick ();
  tick_if event_tick ();

  // Reset is released through two flops so all logic leaves it together.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Mode fields used by the counting logic.
  assign count_en = mode_q[BIT_COUNT_ENABLE];
  assign ext_sel = mode_q[BIT_EXTERNAL_CLOCK];
  assign pulse_en = mode_q[BIT_PULSE_OUTPUT];

  // Internal source picks instruction or oscillator clock.
  rate_prescaler u_presc (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .tick_in(mode_q[BIT_HIGH_SPEED] ? hosc_tick_in : fcpu_tick_in),
    .hold_in(!count_en || ext_sel),
    .rate_in(mode_q[BIT_RATE_HI:BIT_RATE_LO]),
    .div_out(presc_tick.src)
  );

  event_edge_detect u_event (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .pin_in(event_pin_in),
    .edge_out(event_tick.src)
  );

  // Events skip the prescaler, so the rate bits do nothing in this mode.
  assign count_tick = ext_sel ? event_tick.tick : presc_tick.tick;
  // Green mode is deliberately not looked at: counting goes on as usual.
  assign overflow = count_en && count_tick &&
    (count_q == COUNT_FULL_SCALE);
  assign count_next = count_q + 8'h01;

  // APB decode; the access completes on the edge where pready is seen.
  assign word_idx = paddr_in[ADDR_W-1:2];
  assign mapped = (word_idx == IDX_MODE_CONTROL) ||
    (word_idx == IDX_COUNTER_VALUE) || (word_idx == IDX_RELOAD_BUFFER) ||
    (word_idx == IDX_DUTY_COMPARE) || (word_idx == IDX_STATUS_CONTROL);
  assign wr_stb = psel_in && penable_in && pready_q && pwrite_in && mapped;
  assign wr_mode = wr_stb && (word_idx == IDX_MODE_CONTROL);
  assign wr_count = wr_stb && (word_idx == IDX_COUNTER_VALUE);
  assign wr_reload = wr_stb && (word_idx == IDX_RELOAD_BUFFER);
  assign wr_duty = wr_stb && (word_idx == IDX_DUTY_COMPARE);
  assign wr_status = wr_stb && (word_idx == IDX_STATUS_CONTROL);

  // Read mux; the reload buffer is write-only and reads as zero.
  always_comb begin
    rd_mux = 8'h00;
    case (word_idx)
      IDX_MODE_CONTROL: rd_mux = mode_q;
      IDX_COUNTER_VALUE: rd_mux = count_q;
      IDX_DUTY_COMPARE: rd_mux = duty_q;
      IDX_STATUS_CONTROL: rd_mux = {6'h00, ien_q, flag_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Answer is prepared in the setup cycle and shown for the access phase.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= APB_IDLE;
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      case (phase_q)
        APB_IDLE: begin
          if (psel_in && !penable_in) begin
            phase_q <= APB_ACCESS;
            pready_q <= 1'b1;
            prdata_q <= {24'h000000, rd_mux};
            pslverr_q <= !mapped;
          end
        end
        APB_ACCESS: begin
          phase_q <= APB_IDLE;
          pready_q <= 1'b0;
          prdata_q <= '0;
          pslverr_q <= 1'b0;
        end
        default: begin
          phase_q <= APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // Mode register; a software write beats the hardware clear.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= RST_MODE_CONTROL;
    end else if (wr_mode) begin
      mode_q <= pwdata_in[7:0];
    end else if (overflow && mode_q[BIT_SINGLE_PULSE] && pulse_en) begin
      mode_q[BIT_PULSE_OUTPUT] <= 1'b0;
    end
  end

  // Counter: software write first, then reload on overflow, then count.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= RST_COUNTER_VALUE;
    end else if (wr_count) begin
      count_q <= pwdata_in[7:0];
    end else if (overflow) begin
      count_q <= reload_q;
    end else if (count_en && count_tick) begin
      count_q <= count_next;
    end
  end

  // The buffer is only sampled at overflow, so the running period holds.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= RST_RELOAD_BUFFER;
    end else if (wr_reload) begin
      reload_q <= pwdata_in[7:0];
    end
  end

  // Duty is shadowed so a mid-cycle write cannot chop a pulse.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= RST_DUTY_COMPARE;
      duty_live_q <= RST_DUTY_COMPARE;
    end else begin
      if (wr_duty) begin
        duty_q <= pwdata_in[7:0];
      end
      if (overflow || !count_en) begin
        duty_live_q <= wr_duty ? pwdata_in[7:0] : duty_q;
      end
    end
  end

  // Overflow flag: the hardware set wins over a write-one clear.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      ien_q <= 1'b0;
    end else begin
      if (overflow) begin
        flag_q <= 1'b1;
      end else if (wr_status && pwdata_in[BIT_OVERFLOW_FLAG]) begin
        flag_q <= 1'b0;
      end
      if (wr_status) begin
        ien_q <= pwdata_in[BIT_OVERFLOW_IEN];
      end
    end
  end

  // PWM wave; a duty not above the reload value keeps the output low.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
    end else if (!count_en) begin
      pwm_q <= duty_live_q > count_q;
    end else if (overflow) begin
      pwm_q <= duty_live_q > reload_q;
    end else if (count_tick && (count_next == duty_live_q)) begin
      pwm_q <= 1'b0;
    end
  end

  // Pin sharing and interrupt outputs; all registered. With pulse output
  // on and single pulse off, the pin simply follows the continuous PWM wave.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_level_out <= 1'b0;
      pin_oe_n_out <= 1'b1;
      irq_request_out <= 1'b0;
      irq_vector_out <= OVERFLOW_VECTOR;
      wake_request_out <= 1'b0;
    end else begin
      pin_level_out <= pulse_en ? pwm_q : gpio_level_in;
      pin_oe_n_out <= pulse_en ? 1'b0 : gpio_oe_n_in;
      irq_request_out <= flag_q && ien_q;
      irq_vector_out <= OVERFLOW_VECTOR;
      wake_request_out <= 1'b0;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;

  // Checks on the counting core, pin, interrupt and APB outputs.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  AST_HOLD_WHEN_OFF: assert property (
    !count_en && !wr_count |=> $stable(count_q))
    else $error("Counter moved while disabled.");
  AST_INCREMENT: assert property (
    count_en && count_tick && !overflow && !wr_count
      |=> count_q == $past(count_q) + 8'h01)
    else $error("Counter did not advance by one.");
  AST_FLAG_SET: assert property (
    overflow |=> flag_q ##1
      (flag_q || $past(wr_status && pwdata_in[BIT_OVERFLOW_FLAG])))
    else $error("Overflow flag not held after overflow.");
  AST_RELOAD: assert property (
    overflow && !wr_count |=> count_q == $past(reload_q))
    else $error("Counter not reloaded on overflow.");
  AST_IRQ: assert property (
    flag_q && ien_q |=> irq_request_out)
    else $error("Interrupt request missing.");
  AST_ONE_PULSE: assert property (
    overflow && mode_q[BIT_SINGLE_PULSE] && pulse_en && !wr_mode
      |=> !pulse_en ##1 pin_oe_n_out == $past(gpio_oe_n_in))
    else $error("Single pulse did not end at overflow.");
  AST_EXT_COUNT: assert property (
    ext_sel && count_en && event_tick.tick && !overflow && !wr_count
      && !wr_mode |=> count_q == $past(count_q) + 8'h01)
    else $error("Event did not count undivided.");
  AST_PIN_MUX: assert property (
    pulse_en |=> pin_level_out == $past(pwm_q) && !pin_oe_n_out)
    else $error("PWM not on the shared pin.");
  AST_PWM_RESTART: assert property (
    overflow && (duty_live_q > reload_q) |=> pwm_q)
    else $error("PWM not high at cycle start.");
  AST_NO_WAKE: assert property (
    green_mode_in && overflow |=> ##1 !wake_request_out)
    else $error("Wake request raised.");
  AST_APB_READY: assert property (
    psel_in && !penable_in && phase_q == APB_IDLE |=> pready_out)
    else $error("APB access not answered.");
  // Sticky flag, pin hand-back and the duty match edge of the wave.
  AST_FLAG_STICKY: assert property (
    flag_q && !(wr_status && pwdata_in[BIT_OVERFLOW_FLAG]) |=> flag_q)
    else $error("Overflow flag dropped without a clear.");
  AST_GPIO_RETURN: assert property (
    rst_n && !pulse_en |=> pin_oe_n_out == $past(gpio_oe_n_in) &&
      pin_level_out == $past(gpio_level_in))
    else $error("Pin not handed back to the port.");
  AST_PWM_FALL: assert property (
    count_en && count_tick && !overflow &&
      (count_next == duty_live_q) |=> !pwm_q)
    else $error("PWM did not fall at the duty match.");

  COV_OVERFLOW: cover property (overflow ##1 irq_request_out);
  COV_SINGLE_PULSE: cover property (
    overflow && mode_q[BIT_SINGLE_PULSE] && pulse_en);
  COV_EVENT_COUNT: cover property (ext_sel && count_en && event_tick.tick);
  COV_PWM_FALL: cover property (pulse_en && $fell(pwm_q));
  COV_RELOAD_WRITE: cover property (wr_reload && count_en);
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the 8-bit timer/counter with PWM.
// Assumes: Registers are reached over APB with one access cycle.
// Notes: Prescaler phase is unknown, so rate checks allow one count slack.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import timer_counter_pkg::*;
  localparam logic [11:0] A_MODE = {IDX_MODE_CONTROL, 2'b00};
  localparam logic [11:0] A_CNT = {IDX_COUNTER_VALUE, 2'b00};
  localparam logic [11:0] A_REL = {IDX_RELOAD_BUFFER, 2'b00};
  localparam logic [11:0] A_DUTY = {IDX_DUTY_COMPARE, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_STATUS_CONTROL, 2'b00};
  typedef struct {
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] ex;
    logic er;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_level, pin_oe_n, irq, wake;
  logic [15:0] vector;
  logic fcpu = 1'b0;
  logic hosc = 1'b0;
  logic ev = 1'b1;
  logic green = 1'b0;
  logic gpio_lvl = 1'b1;
  logic gpio_oe_n = 1'b1;
  logic [1:0] cyc = 2'b00;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int comparisons = 0;
  row_t rows[6];
  int hi_cnt, oe_cnt;
  logic [31:0] v;

  always #4 clk = ~clk;

  // Instruction ticks every fourth cycle, oscillator ticks every second.
  always @(posedge clk) begin
    cyc <= cyc + 2'd1;
    fcpu <= (cyc == 2'd3);
    hosc <= cyc[0];
  end

  timer_counter_pwm_8bit u_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .fcpu_tick_in(fcpu), .hosc_tick_in(hosc),
    .event_pin_in(ev), .green_mode_in(green), .gpio_level_in(gpio_lvl),
    .gpio_oe_n_in(gpio_oe_n), .pin_level_out(pin_level),
    .pin_oe_n_out(pin_oe_n), .irq_request_out(irq),
    .irq_vector_out(vector), .wake_request_out(wake)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (rdat[0] !== 1'b1 && n < 150);
    chk(32'(rdat[0]), 32'h1);
  endtask

  // Count for w cycles with code k and check the count against e.
  task automatic run_rate(input logic [2:0] k, input logic hs, input int w,
                          input int e);
    apb(1'b1, A_CNT, 32'h0);
    apb(1'b1, A_MODE, 32'({1'b0, k, 1'b0, hs, 2'b00}));
    apb(1'b1, A_MODE, 32'({1'b1, k, 1'b0, hs, 2'b00}));
    repeat (w) @(posedge clk);
    apb(1'b1, A_MODE, 32'({1'b0, k, 1'b0, hs, 2'b00}));
    apb(1'b0, A_CNT, 32'h0);
    chk(32'(rdat >= e - 1 && rdat <= e + 1), 32'h1);
  endtask

  task automatic final_report();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly five and a half thousand cycles of tests.
  initial begin
    #240000;
    err_total = err_total + 1;
    final_report();
  end

  initial begin
    rows[0] = '{A_MODE, 32'h7E, 32'h7E, 1'b0};
    rows[1] = '{A_CNT, 32'h5A, 32'h5A, 1'b0};
    rows[2] = '{A_DUTY, 32'hC3, 32'hC3, 1'b0};
    rows[3] = '{A_REL, 32'h11, 32'h0, 1'b0};
    rows[4] = '{A_STAT, 32'h2, 32'h2, 1'b0};
    rows[5] = '{12'h300, 32'h55, 32'h0, 1'b1};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(pin_oe_n), 32'h1);
    chk(32'(vector), 32'h000C);
    apb(1'b0, A_MODE, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, A_CNT, 32'h0);
    chk(rdat, 32'h0);
    // Register table rows: write, then read back.
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      chk(32'(rerr), 32'(rows[i].er));
      apb(1'b0, rows[i].a, 32'h0);
      chk(rdat, rows[i].ex);
      chk(32'(rerr), 32'(rows[i].er));
    end
    // Overflow, reload, interrupt and double-buffered reload.
    apb(1'b1, A_MODE, 32'h70);
    apb(1'b1, A_CNT, 32'hF0);
    apb(1'b1, A_REL, 32'hF0);
    apb(1'b1, A_STAT, 32'h3);
    apb(1'b1, A_MODE, 32'hF0);
    wait_flag();
    chk(32'(irq), 32'h1);
    apb(1'b1, A_REL, 32'h00);
    apb(1'b0, A_CNT, 32'h0);
    chk(32'(rdat >= 32'hF0), 32'h1);
    apb(1'b1, A_STAT, 32'h3);
    apb(1'b0, A_STAT, 32'h0);
    chk(rdat, 32'h2);
    chk(32'(irq), 32'h0);
    wait_flag();
    apb(1'b0, A_CNT, 32'h0);
    chk(32'(rdat <= 32'h10), 32'h1);
    apb(1'b1, A_MODE, 32'h70);
    apb(1'b0, A_CNT, 32'h0);
    v = rdat;
    repeat (100) @(posedge clk);
    apb(1'b0, A_CNT, 32'h0);
    chk(rdat, v);
    // Every prescale code from the instruction clock, one from oscillator.
    for (int k = 0; k < 8; k++) begin
      run_rate(3'(k), 1'b0, 512, 128 >> (7 - k));
    end
    run_rate(3'd6, 1'b1, 256, 64);
    // Event counting ignores the prescale code and the internal ticks.
    apb(1'b1, A_CNT, 32'h0);
    apb(1'b1, A_MODE, 32'h08);
    apb(1'b1, A_MODE, 32'h88);
    repeat (5) begin
      @(posedge clk);
      ev <= 1'b0;
      repeat (8) @(posedge clk);
      ev <= 1'b1;
      repeat (8) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    apb(1'b1, A_MODE, 32'h08);
    apb(1'b0, A_CNT, 32'h0);
    chk(rdat, 32'h5);
    // PWM in green mode: half the period high with reload F0, duty F8.
    green <= 1'b1;
    apb(1'b1, A_CNT, 32'hF0);
    apb(1'b1, A_REL, 32'hF0);
    apb(1'b1, A_DUTY, 32'hF8);
    apb(1'b1, A_MODE, 32'h71);
    apb(1'b1, A_MODE, 32'hF1);
    repeat (8) @(posedge clk);
    hi_cnt = 0;
    oe_cnt = 0;
    repeat (256) begin
      @(posedge clk);
      hi_cnt += int'(pin_level === 1'b1);
      oe_cnt += int'(pin_oe_n === 1'b0);
      if (wake !== 1'b0) chk(32'(wake), 32'h0);
    end
    chk(32'(hi_cnt >= 112 && hi_cnt <= 144), 32'h1);
    chk(32'(oe_cnt), 32'd256);
    apb(1'b1, A_MODE, 32'hF0);
    // The pin must follow the port's own level and enable again.
    gpio_lvl <= 1'b0;
    gpio_oe_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(pin_oe_n), 32'h0);
    chk(32'(pin_level), 32'h0);
    gpio_lvl <= 1'b1;
    gpio_oe_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(pin_oe_n), 32'h1);
    chk(32'(pin_level), 32'h1);
    // Single pulse: overflow clears the pulse output bit.
    apb(1'b1, A_MODE, 32'h70);
    apb(1'b1, A_CNT, 32'hF0);
    apb(1'b1, A_STAT, 32'h3);
    apb(1'b1, A_MODE, 32'h73);
    apb(1'b1, A_MODE, 32'hF3);
    repeat (4) @(posedge clk);
    chk(32'(pin_oe_n), 32'h0);
    wait_flag();
    repeat (3) @(posedge clk);
    apb(1'b0, A_MODE, 32'h0);
    chk(rdat, 32'hF2);
    chk(32'(pin_oe_n), 32'h1);
    // Reset again while counting: mode, counter, status, interrupt and pin enable must come back cleared.
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, A_MODE, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, A_CNT, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, A_STAT, 32'h0);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(pin_oe_n), 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
